// >>> rtl/special_if.sv
// Speaker gate, keylock and reset routing glue for the board.
// Assumes an I/O write/read strobe pair on the system clock, a timer
// tone already synchronous to clk, and a CPU reset that is active high.
`timescale 1ns/1ns
module special_if #(
    parameter int DEBOUNCE_CYC = special_if_pkg::DEBOUNCE_CYC,
    parameter int CPU_RST_CYC = special_if_pkg::CPU_RST_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // I/O port access
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Speaker path
    input wire logic timer_tone,
    output logic speaker_drive_out,
    output logic speaker_drv_en,
    // Keyboard and keylock
    input wire logic keylock_n,
    input wire logic kbd_data_in,
    output logic kbd_data_out,
    // Reset sources and outputs
    input wire logic front_panel_reset_n,
    input wire logic kbc_cpu_rst_n,
    output logic board_rst,
    output logic cpu_rst
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE,
        RS_BOARD,
        RS_CPU
    } rst_state_t;

    typedef struct packed {
        logic [7:0] sys_ctrl;
        logic [7:0] spk_en;
        logic [7:0] rdata;
        logic kbc_s1;
        logic kbc_s2;
        logic kbc_prev;
        rst_state_t rst_st;
        logic [31:0] rst_cnt;
        logic spk_out;
        logic spk_drv;
        logic kbd_out;
        logic board_rst;
        logic cpu_rst;
    } core_t;

    core_t st_r;
    core_t st_nxt;
    logic fp_level;
    logic lock_level;
    logic kbc_fall;
    logic gated_tone;

    // ------------------------------------------------------------------
    // Switch filters
    // ------------------------------------------------------------------
    // both switch contacts filtered
    switch_debounce #(.COUNT(DEBOUNCE_CYC)) u_fp_deb (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw_in(front_panel_reset_n),
        .level_out(fp_level)
    );

    switch_debounce #(.COUNT(DEBOUNCE_CYC)) u_lock_deb (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw_in(keylock_n),
        .level_out(lock_level)
    );

    // ------------------------------------------------------------------
    // Speaker path
    // ------------------------------------------------------------------
    // tone is the timer counter output
    // control bit 0 gates the tone
    assign gated_tone = timer_tone &
        st_r.sys_ctrl[special_if_pkg::TONE_GATE_BIT];

    // Pulse from controller is low-going; edge seen on synced copy only
    assign kbc_fall = st_r.kbc_prev & ~st_r.kbc_s2;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Register writes
        if (io_wr && io_addr == special_if_pkg::SYS_CTRL_ADDR) begin
            st_nxt.sys_ctrl = io_wdata;
        end
        if (io_wr && io_addr == special_if_pkg::SPK_EN_ADDR) begin
            st_nxt.spk_en = io_wdata;
        end
        // Reads return stored bits; unmapped ports read zero
        if (io_rd && io_addr == special_if_pkg::SYS_CTRL_ADDR) begin
            st_nxt.rdata = st_r.sys_ctrl;
        end else if (io_rd && io_addr == special_if_pkg::SPK_EN_ADDR) begin
            st_nxt.rdata = st_r.spk_en;
        end else begin
            st_nxt.rdata = 8'h00;
        end
        // data bit combines with gated tone
        st_nxt.spk_out = gated_tone &
            st_r.sys_ctrl[special_if_pkg::SPK_DATA_BIT];
        st_nxt.spk_drv = st_r.spk_en[special_if_pkg::SPK_DRV_EN_BIT];
        st_nxt.kbd_out = lock_level ? kbd_data_in : 1'b1;
        // Controller output sync
        st_nxt.kbc_s1 = kbc_cpu_rst_n;
        st_nxt.kbc_s2 = st_r.kbc_s1;
        st_nxt.kbc_prev = st_r.kbc_s2;
        // Reset routing; front panel has priority over software pulse
        case (st_r.rst_st)
            RS_IDLE: begin
                if (!fp_level) begin
                    st_nxt.rst_st = RS_BOARD;
                end else if (kbc_fall) begin
                    st_nxt.rst_st = RS_CPU;
                    st_nxt.rst_cnt = '0;
                end
            end
            RS_BOARD: begin
                if (fp_level) begin
                    st_nxt.rst_st = RS_IDLE;
                end
            end
            RS_CPU: begin
                if (!fp_level) begin
                    st_nxt.rst_st = RS_BOARD;
                end else if (st_r.rst_cnt >= 32'(CPU_RST_CYC - 1)) begin
                    st_nxt.rst_st = RS_IDLE;
                end else begin
                    st_nxt.rst_cnt = st_r.rst_cnt + 32'd1;
                end
            end
            default: begin
                st_nxt.rst_st = RS_IDLE;
            end
        endcase
        st_nxt.board_rst = (st_nxt.rst_st == RS_BOARD);
        st_nxt.cpu_rst = (st_nxt.rst_st != RS_IDLE);
        // board registers reinitialised by panel reset
        if (st_r.board_rst) begin
            st_nxt.sys_ctrl = special_if_pkg::SYS_CTRL_RST;
            st_nxt.spk_en = special_if_pkg::SPK_EN_RST;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // no key combo input
    // Key combo only redirects the CPU in firmware, so no line is driven
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{sys_ctrl: special_if_pkg::SYS_CTRL_RST,
                      spk_en: special_if_pkg::SPK_EN_RST,
                      rdata: 8'h00, kbc_s1: 1'b1, kbc_s2: 1'b1,
                      kbc_prev: 1'b1, rst_st: RS_IDLE, rst_cnt: '0,
                      spk_out: 1'b0, spk_drv: 1'b0, kbd_out: 1'b1,
                      board_rst: 1'b0, cpu_rst: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign io_rdata = st_r.rdata;
    assign speaker_drive_out = st_r.spk_out;
    assign speaker_drv_en = st_r.spk_drv;
    assign kbd_data_out = st_r.kbd_out;
    assign board_rst = st_r.board_rst;
    assign cpu_rst = st_r.cpu_rst;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_tone_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !st_r.sys_ctrl[0] |=> !speaker_drive_out)
        else $error("tone passed while gate bit clear");

    a_spk_data: assert property (@(posedge clk) disable iff (sys_rst)
        (timer_tone && st_r.sys_ctrl[1:0] == 2'b11) |=> speaker_drive_out)
        else $error("speaker data did not reach drive output");

    a_tone_source: assert property (@(posedge clk) disable iff (sys_rst)
        speaker_drive_out |-> $past(timer_tone))
        else $error("speaker toggled without timer tone");

    a_drv_enable: assert property (@(posedge clk) disable iff (sys_rst)
        speaker_drv_en |-> $past(st_r.spk_en[6]))
        else $error("driver enabled with bit 6 clear");

    a_key_lock: assert property (@(posedge clk) disable iff (sys_rst)
        !lock_level |=> kbd_data_out)
        else $error("keyboard data passed while locked");

    a_panel_rst: assert property (@(posedge clk) disable iff (sys_rst)
        (!fp_level && st_r.rst_st == RS_IDLE) |=> board_rst && cpu_rst)
        else $error("panel reset did not reset board and CPU");

    sequence s_kbc_pulse;
        fp_level && st_r.rst_st == RS_IDLE && kbc_fall;
    endsequence

    a_sw_cpu_only: assert property (@(posedge clk) disable iff (sys_rst)
        s_kbc_pulse |=> cpu_rst && !board_rst)
        else $error("software reset reached board logic");

    a_kbc_reset: assert property (@(posedge clk) disable iff (sys_rst)
        s_kbc_pulse ##1 fp_level [*2] |-> cpu_rst)
        else $error("controller pulse did not hold CPU reset");

endmodule : special_if

// >>> rtl/special_if_pkg.sv
// Constants shared by the speaker, keylock and reset glue logic.
// Assumes a 10 MHz system clock and a synchronous board reset.
//
// Function
// - The speaker tone is taken from a timer counter output, never made here.
// - Bit 0 of the control port at 61h gates the timer tone on or off.
// - Bit 1 of the control port is speaker data combined with the gated tone.
// - Bit 6 of speaker_driver_enable_port must be set for the speaker drive to be active.
// - While the low-active keylock input is asserted keyboard input is blocked.
// - The low-active front-panel reset forces a reset of all board hardware.
// - A software reset resets only the CPU, not coprocessor or board logic.
// - A pulse on keyboard controller output bit 0 is turned into a CPU reset.
// - The three-key keyboard reset drives no hardware reset line at all.
package special_if_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SYS_CTRL_ADDR = 8'h61;
    localparam logic [7:0] SPK_EN_ADDR = 8'h79;
    localparam int TONE_GATE_BIT = 0;
    localparam int SPK_DATA_BIT = 1;
    localparam int SPK_DRV_EN_BIT = 6;
    localparam logic [7:0] SYS_CTRL_RST = 8'h00;
    localparam logic [7:0] SPK_EN_RST = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CPU_RST_US = 10;
    localparam int CPU_RST_CYC = (CPU_RST_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

endpackage : special_if_pkg

// >>> rtl/switch_debounce.sv
// Two-flop synchroniser and debounce filter for one switch input.
// Assumes the input is an asynchronous mechanical contact.
`timescale 1ns/1ns
module switch_debounce #(
    parameter int COUNT = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw switch and filtered level
    input wire logic raw_in,
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [31:0] cnt;
    } deb_t;

    deb_t st_r;
    deb_t st_nxt;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    // sync then debounce
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = raw_in;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.lvl) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= 32'(COUNT - 1)) begin
            st_nxt.lvl = st_r.s2;
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'd1;
        end
    end

    // Idle level is high: switches are low-active
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.lvl;

    // level moves only after stable input
    a_deb_stable: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(level_out) |-> $past(st_r.s2) == level_out)
        else $error("debounced level changed without stable input");

endmodule : switch_debounce

// >>> sim/far_side.sv
// Far side model: speaker driver, panel reset switch and keylock.
// Assumes the bench moves press and lock on the falling edge.
`timescale 1ns/1ns
module far_side (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic press,
    input wire logic lock,
    // Speaker driver
    input wire logic speaker_drive_out,
    input wire logic speaker_drv_en,
    output logic sound,
    // Switch contacts, low when closed
    output logic front_panel_reset_n,
    output logic keylock_n
);
    logic last = 1'b0;
    logic fp_q = 1'b1;
    logic kl_q = 1'b1;
    int bnc = 0;

    assign sound = speaker_drive_out & speaker_drv_en;

    // panel contact chatters
    // Glitches are one cycle wide, so a filter must not pass them
    // Rising edge: never races the falling-edge bench controls
    always @(posedge clk) begin
        if (last != press) begin
            last <= press;
            bnc <= 5;
        end else if (bnc > 0) begin
            bnc <= bnc - 1;
        end
        fp_q <= (bnc > 0) ? bnc[0] : ~press;
        kl_q <= ~lock;
    end

    // Contacts open at power-up, one driver per contact
    assign front_panel_reset_n = fp_q;
    assign keylock_n = kl_q;
endmodule : far_side

// >>> sim/test_speaker_gate_and_reset_routing.sv
// Self-checking bench for the speaker, keylock and reset glue.
// Assumes short debounce and CPU reset counts set below.
`timescale 1ns/1ns
module test_speaker_gate_and_reset_routing;
    logic clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, tone = 0, kin = 1;
    logic kbc_n = 1, press = 0, lock = 0, mon = 0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
    logic [7:0] m61 = 8'h00, m79 = 8'h00, lf = 8'h30;
    logic spk, en, kout, brst, crst, snd, fp_n, kl_n, xs, xe, xk;
    int bad_count = 0, total_checks = 0, n, a, b;

    special_if #(.DEBOUNCE_CYC(4), .CPU_RST_CYC(3)) special_if_i (
        .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .timer_tone(tone), .speaker_drive_out(spk), .speaker_drv_en(en),
        .keylock_n(kl_n), .kbd_data_in(kin), .kbd_data_out(kout),
        .front_panel_reset_n(fp_n), .kbc_cpu_rst_n(kbc_n),
        .board_rst(brst), .cpu_rst(crst));
    far_side far_side_i (.clk(clk), .press(press), .lock(lock),
        .speaker_drive_out(spk), .speaker_drv_en(en), .sound(snd),
        .front_panel_reset_n(fp_n), .keylock_n(kl_n));

    initial forever #50 clk = ~clk;

    function automatic logic [7:0] lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(negedge clk);
        io_addr = ad;
        io_wdata = d;
        io_wr = 1;
        @(negedge clk);
        io_wr = 0;
    endtask : wr

    task automatic rd(logic [7:0] ad, logic [7:0] e, string nm);
        @(negedge clk);
        io_addr = ad;
        io_rd = 1;
        @(negedge clk);
        io_rd = 0;
        chk(nm, io_rdata, e);
    endtask : rd

    // Random tone and keyboard data, fresh every cycle
    always @(negedge clk) begin
        lf <= lfsr(lf);
        tone <= lf[0];
        kin <= lf[3];
    end

    // Reference model: ports and registered outputs
    always @(posedge clk) begin
        xs <= tone & m61[0] & m61[1];
        xe <= m79[6];
        xk <= kin | lock;
        if (sys_rst || press) begin
            m61 <= 8'h00;
            m79 <= 8'h00;
        end else if (io_wr && io_addr == special_if_pkg::SYS_CTRL_ADDR) begin
            m61 <= io_wdata;
        end else if (io_wr && io_addr == special_if_pkg::SPK_EN_ADDR) begin
            m79 <= io_wdata;
        end
    end

    // Compare outputs with the model once settled
    always @(negedge clk) begin
        if (mon) begin
            chk("speaker", spk, xs);
            chk("drv_en", en, xe);
            chk("kbd", kout, xk);
            chk("sound", snd, xs & xe);
        end
    end

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #500000;
        bad_count++;
        final_report;
    end

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 0;
        rd(8'h61, 8'h00, "p61_rst");
        rd(8'h79, 8'h00, "p79_rst");
        mon = 1;
        wr(8'h61, 8'h03);
        wr(8'h79, 8'h40);
        repeat (16) @(negedge clk);
        for (n = 0; n < 12; n++) begin
            wr(8'h61, lf);
            wr(8'h79, lf ^ 8'h5a);
            rd(8'h61, m61, "p61");
            rd(8'h79, m79, "p79");
        end
        wr(8'h62, 8'hff);
        rd(8'h62, 8'h00, "unmapped");
        chk("no_key_rst", 8'({brst, crst}), 8'h00);
        mon = 0;
        lock = 1;
        repeat (20) @(negedge clk);
        mon = 1;
        repeat (20) @(negedge clk);
        mon = 0;
        lock = 0;
        repeat (20) @(negedge clk);
        mon = 1;
        wr(8'h61, 8'h03);
        kbc_n = 0;
        // Two sync edges, then state and output rise together
        repeat (2) @(negedge clk);
        chk("cpu_rst_early", crst, 8'h00);
        kbc_n = 1;
        @(negedge clk);
        chk("cpu_rst_on", crst, 8'h01);
        a = 1;
        b = 0;
        repeat (10) begin
            @(negedge clk);
            a += (crst === 1'b1);
            b += (brst !== 1'b0);
        end
        chk("cpu_rst_len", 8'(a), 8'h03);
        chk("board_quiet", 8'(b), 8'h00);
        rd(8'h61, 8'h03, "p61_kept");
        mon = 0;
        press = 1;
        n = 0;
        while (brst !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        wr(8'h61, 8'hff);
        chk("board_rst", brst, 8'h01);
        chk("cpu_by_panel", crst, 8'h01);
        press = 0;
        repeat (30) @(negedge clk);
        chk("board_off", brst, 8'h00);
        chk("cpu_off", crst, 8'h00);
        rd(8'h61, 8'h00, "p61_clr");
        rd(8'h79, 8'h00, "p79_clr");
        mon = 1;
        repeat (10) @(negedge clk);
        final_report;
    end
endmodule : test_speaker_gate_and_reset_routing
